// ### core/cesh_core.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - Error count saved to nonvolatile copy hourly
// - Selection 3 runs at fallback frequency
// - Fallback 9999 keeps pre-error frequency
// - Error cleared within wait: no fault
// - Option fault stops at once by selection
// - Expired line error acts by selection
// - Error removal acts by selection
// - Fault codes HA1 line, HF1 option
// - Fault output drives alarm, bit, history
// - Unasserted fault record held only temporarily
// - Decel and restart use ordinary ramps
// - Selection 2 restart reuses prior command
// - Selection 2 re-accelerates if removed decelerating
// - Communication stops; option trips only networked
// - Network inverter reset only in network mode
// - Error reset scope 0 all, 1 network
// - Terminal, power, panel resets always accepted
// - Error reset only while fault active
// - Line error counts at once, before the wait time
// - Count increments per error, 0 clears
module cesh_core #(
   parameter int TICK_CYCLES = cesh_pkg::TICK_CYCLES,
   parameter int HOUR_TICKS  = cesh_pkg::HOUR_TICKS
) (
   input  wire logic        sys_clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out,
   input  wire logic        line_error_in,
   input  wire logic        option_fault_in,
   input  wire logic        reset_terminal_in,
   input  wire logic        panel_reset_in,
   input  wire logic        net_inverter_reset_in,
   input  wire logic        net_error_reset_request_in,
   input  wire logic        motor_stopped_in,
   input  wire logic        run_cmd_in,
   input  wire logic [13:0] speed_cmd_in,
   output logic             run_out,
   output logic      [13:0] freq_out,
   output logic             coast_out,
   output logic             decel_out,
   output logic             alarm_output_out,
   output logic             fault_bit_out,
   output logic      [7:0]  line_fault_indication_out,
   output logic             comm_stop_out,
   output logic             inverter_reset_out
);

   // Merges a write into a register word by byte enable.
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   logic [6:0]  sync1_r, sync2_r, prev_r, rise;
   logic        line_err, opt_err, net_mode, wr, count_clr, accept_rst;
   logic        expired, tick_r, scope_r, src_opt_r, held_run_r, use_held_r;
   logic [1:0]  sel_r, opm_r;
   logic [13:0] wait_r, fallback_r, wait_cnt_r, held_speed_r;
   logic [15:0] count_r, saved_r, hour_cnt_r;
   logic [22:0] tick_cnt_r;
   logic [31:0] ctrl_word, ctrl_wr, wait_wr, freq_wr;
   logic [7:0]  hist_r, temp_code_r;
   cesh_pkg::cesh_state_type st_r;

   // External levels pass two flip-flops; edges compare the second stage with a third.
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         sync1_r <= 7'h00;
         sync2_r <= 7'h00;
         prev_r  <= 7'h00;
      end else begin
         sync1_r <= {motor_stopped_in, net_error_reset_request_in,
                     net_inverter_reset_in, panel_reset_in,
                     reset_terminal_in, option_fault_in, line_error_in};
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   // Decoded levels and merged write words. A write lands on the edge at
   // which the master sees ack, so it never runs ahead of the bus cycle.
   assign rise     = sync2_r & ~prev_r;
   assign line_err = sync2_r[0];
   assign opt_err  = sync2_r[1];
   assign net_mode = (opm_r == cesh_pkg::OPM_NET);
   assign wr       = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out;
   assign ctrl_wr  = merge(ctrl_word, wb_dat_in, wb_sel_in);
   assign wait_wr  = merge({18'h0_0000, wait_r}, wb_dat_in, wb_sel_in);
   assign freq_wr  = merge({18'h0_0000, fallback_r}, wb_dat_in, wb_sel_in);
   assign ctrl_word = {26'h000_0000, opm_r, 1'b0, scope_r, sel_r};
   assign count_clr = wr && (wb_adr_in == cesh_pkg::ADDR_COUNT)
                      && (merge(32'h0000_0000, wb_dat_in, wb_sel_in)
                          == 32'h0000_0000);
   assign expired  = line_err && (wait_cnt_r >= wait_r);

   // Network resets are refused while the line itself is in error.
   assign accept_rst = rise[2] || rise[3]
      || (rise[4] && net_mode && !line_err)
      || (rise[5] && (!scope_r || net_mode)
          && alarm_output_out && !line_err);

   // Control registers written by software.
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         sel_r      <= cesh_pkg::SEL_RST;
         scope_r    <= cesh_pkg::SCOPE_RST;
         opm_r      <= cesh_pkg::OPM_RST;
         wait_r     <= cesh_pkg::WAIT_RST;
         fallback_r <= cesh_pkg::FREQ_KEEP;
      end else if (wr) begin
         case (wb_adr_in)
            cesh_pkg::ADDR_CTRL: begin
               opm_r   <= ctrl_wr[cesh_pkg::CTRL_OPM_LSB +: 2];
               scope_r <= ctrl_wr[cesh_pkg::CTRL_SCOPE_BIT];
               sel_r   <= ctrl_wr[cesh_pkg::CTRL_SEL_LSB +: 2];
            end
            cesh_pkg::ADDR_WAIT: wait_r     <= wait_wr[13:0];
            cesh_pkg::ADDR_FREQ: fallback_r <= freq_wr[13:0];
            default: begin
            end
         endcase
      end
   end

   // Wishbone answer: one wait state, ack for one cycle, zero if unmapped.
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end else begin
         wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
         case (wb_adr_in)
            cesh_pkg::ADDR_CTRL:   wb_dat_out <= ctrl_word;
            cesh_pkg::ADDR_WAIT:   wb_dat_out <= {18'h0_0000, wait_r};
            cesh_pkg::ADDR_FREQ:   wb_dat_out <= {18'h0_0000, fallback_r};
            cesh_pkg::ADDR_COUNT:  wb_dat_out <= {16'h0000, count_r};
            cesh_pkg::ADDR_SAVED:  wb_dat_out <= {16'h0000, saved_r};
            cesh_pkg::ADDR_STATUS: wb_dat_out <= {25'h000_0000, st_r,
               src_opt_r, alarm_output_out, sync2_r[1:0]};
            cesh_pkg::ADDR_HIST:   wb_dat_out <= {16'h0000, temp_code_r,
               hist_r};
            default:               wb_dat_out <= 32'h0000_0000;
         endcase
      end
   end

   // The 0.1 s tick, a one-cycle enable for the wait and hour counters.
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         tick_cnt_r <= 23'h00_0000;
         tick_r     <= 1'b0;
      end else if (tick_cnt_r == 23'(TICK_CYCLES - 1)) begin
         tick_cnt_r <= 23'h00_0000;
         tick_r     <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 23'h00_0001;
         tick_r     <= 1'b0;
      end
   end

   // Wait timer restarts on entry to timing and saturates at the top.
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wait_cnt_r <= 14'h0000;
      end else if (st_r != cesh_pkg::ST_TIMING) begin
         wait_cnt_r <= 14'h0000;
      end else if (tick_r && wait_cnt_r != 14'h3FFF) begin
         wait_cnt_r <= wait_cnt_r + 14'h0001;
      end
   end

   // Running count lives here; the saved copy survives drive resets only.
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         count_r    <= cesh_pkg::COUNT_RST;
         saved_r    <= cesh_pkg::COUNT_RST;
         hour_cnt_r <= 16'h0000;
      end else begin
         if (tick_r) begin
            hour_cnt_r <= (hour_cnt_r == 16'(HOUR_TICKS - 1)) ?
                          16'h0000 : hour_cnt_r + 16'h0001;
         end
         if (tick_r && hour_cnt_r == 16'(HOUR_TICKS - 1)) begin
            saved_r <= count_r;
         end
         // A new error in the same cycle as a written clear restarts the count at 1.
         if (rise[0]) begin
            count_r <= count_clr ? 16'h0001 : count_r + 16'h0001;
         end else if (accept_rst) begin
            count_r <= saved_r;
         end else if (count_clr) begin
            count_r <= 16'h0000;
         end
      end
   end

   // Stop sequencing, fault output and history.
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_r             <= cesh_pkg::ST_NORMAL;
         src_opt_r        <= 1'b0;
         coast_out        <= 1'b0;
         decel_out        <= 1'b0;
         alarm_output_out <= 1'b0;
         fault_bit_out    <= 1'b0;
         hist_r           <= cesh_pkg::CODE_NONE;
         temp_code_r      <= cesh_pkg::CODE_NONE;
         held_speed_r     <= 14'h0000;
         held_run_r       <= 1'b0;
         use_held_r       <= 1'b0;
      end else if (accept_rst) begin
         st_r             <= cesh_pkg::ST_NORMAL;
         src_opt_r        <= 1'b0;
         coast_out        <= 1'b0;
         decel_out        <= 1'b0;
         alarm_output_out <= 1'b0;
         fault_bit_out    <= 1'b0;
         temp_code_r      <= cesh_pkg::CODE_NONE;
         use_held_r       <= 1'b0;
      end else begin
         case (st_r)
            cesh_pkg::ST_NORMAL: begin
               // Option faults trip only in network mode.
               if (opt_err && net_mode) begin
                  src_opt_r <= 1'b1;
                  if (sel_r == cesh_pkg::SEL_COAST ||
                      sel_r == cesh_pkg::SEL_FALLBK) begin
                     st_r             <= cesh_pkg::ST_TRIP;
                     coast_out        <= 1'b1;
                     alarm_output_out <= 1'b1;
                     fault_bit_out    <= 1'b1;
                     hist_r           <= cesh_pkg::CODE_OPT;
                  end else begin
                     st_r        <= cesh_pkg::ST_DECEL;
                     decel_out   <= 1'b1;
                     temp_code_r <= cesh_pkg::CODE_OPT;
                  end
               end else if (line_err && net_mode) begin
                  st_r         <= cesh_pkg::ST_TIMING;
                  held_speed_r <= use_held_r ? held_speed_r : speed_cmd_in;
                  held_run_r   <= use_held_r ? held_run_r : run_cmd_in;
               end
            end
            cesh_pkg::ST_TIMING: begin
               if (!line_err) begin
                  st_r <= cesh_pkg::ST_NORMAL;
               end else if (expired) begin
                  case (sel_r)
                     cesh_pkg::SEL_COAST: begin
                        st_r             <= cesh_pkg::ST_TRIP;
                        coast_out        <= 1'b1;
                        alarm_output_out <= 1'b1;
                        fault_bit_out    <= 1'b1;
                        hist_r           <= cesh_pkg::CODE_LINE;
                     end
                     cesh_pkg::SEL_FALLBK: begin
                        st_r <= cesh_pkg::ST_FALLBK;
                     end
                     default: begin
                        st_r        <= cesh_pkg::ST_DECEL;
                        decel_out   <= 1'b1;
                        temp_code_r <= cesh_pkg::CODE_LINE;
                     end
                  endcase
               end
            end
            cesh_pkg::ST_FALLBK: begin
               // No alternative stop here; the reset terminal is the backstop.
               if (!line_err) begin
                  st_r <= cesh_pkg::ST_NORMAL;
               end
            end
            cesh_pkg::ST_DECEL: begin
               if (!src_opt_r && !line_err &&
                   sel_r == cesh_pkg::SEL_RESTART) begin
                  st_r        <= cesh_pkg::ST_NORMAL;
                  decel_out   <= 1'b0;
                  temp_code_r <= cesh_pkg::CODE_NONE;
                  use_held_r  <= 1'b1;
               end else if (sync2_r[6]) begin
                  st_r             <= cesh_pkg::ST_TRIP;
                  decel_out        <= 1'b0;
                  alarm_output_out <= 1'b1;
                  fault_bit_out    <= 1'b1;
                  hist_r           <= temp_code_r;
               end
            end
            cesh_pkg::ST_TRIP: begin
               if (!src_opt_r && !line_err &&
                   sel_r == cesh_pkg::SEL_RESTART) begin
                  st_r             <= cesh_pkg::ST_NORMAL;
                  coast_out        <= 1'b0;
                  alarm_output_out <= 1'b0;
                  fault_bit_out    <= 1'b0;
                  temp_code_r      <= cesh_pkg::CODE_NONE;
                  use_held_r       <= 1'b1;
               end
            end
            default: begin
               st_r <= cesh_pkg::ST_NORMAL;
            end
         endcase
      end
   end

   // Drive command, indication and communication stop.
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         run_out                   <= 1'b0;
         freq_out                  <= 14'h0000;
         line_fault_indication_out <= cesh_pkg::CODE_NONE;
         comm_stop_out             <= 1'b0;
         inverter_reset_out        <= 1'b0;
      end else begin
         inverter_reset_out <= accept_rst;
         comm_stop_out      <= line_err || opt_err;
         line_fault_indication_out <= alarm_output_out ? hist_r
                                      : cesh_pkg::CODE_NONE;
         if (st_r == cesh_pkg::ST_FALLBK) begin
            run_out  <= held_run_r;
            freq_out <= (fallback_r == cesh_pkg::FREQ_KEEP) ?
                        held_speed_r : fallback_r;
         end else if (st_r == cesh_pkg::ST_TRIP ||
                      st_r == cesh_pkg::ST_DECEL) begin
            run_out  <= 1'b0;
            freq_out <= 14'h0000;
         end else if (use_held_r) begin
            run_out  <= held_run_r;
            freq_out <= held_speed_r;
         end else begin
            run_out  <= run_cmd_in;
            freq_out <= speed_cmd_in;
         end
      end
   end

   chk_count_step: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) rise[0] && !count_clr
      |=> count_r == $past(count_r) + 16'h0001)
      else $error("count did not step");
   chk_filter_ok: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      st_r == cesh_pkg::ST_TIMING && !line_err && !accept_rst
      |=> st_r == cesh_pkg::ST_NORMAL && !alarm_output_out)
      else $error("cleared line error raised fault");
   chk_sel0_coast: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) st_r == cesh_pkg::ST_TIMING && expired
      && sel_r == cesh_pkg::SEL_COAST && !accept_rst
      |=> coast_out && alarm_output_out && hist_r == cesh_pkg::CODE_LINE)
      else $error("selection 0 did not coast");
   chk_opt_immediate: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) st_r == cesh_pkg::ST_NORMAL && opt_err
      && net_mode && sel_r == cesh_pkg::SEL_FALLBK && !accept_rst
      |=> alarm_output_out ##1 line_fault_indication_out
          == cesh_pkg::CODE_OPT)
      else $error("option fault not immediate");
   chk_fallback_freq: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) st_r == cesh_pkg::ST_FALLBK
      |=> freq_out == (($past(fallback_r) == cesh_pkg::FREQ_KEEP) ?
          $past(held_speed_r) : $past(fallback_r)))
      else $error("fallback frequency wrong");
   chk_sel2_reaccel: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) st_r == cesh_pkg::ST_DECEL && !src_opt_r
      && !line_err && sel_r == cesh_pkg::SEL_RESTART
      |=> st_r == cesh_pkg::ST_NORMAL && !decel_out ##1 run_out
          == held_run_r)
      else $error("no re-acceleration");
   chk_net_reset_mode: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) rise[4] && !net_mode && !rise[2]
      && !rise[3] && !rise[5] |=> !inverter_reset_out)
      else $error("network reset outside network mode");
   chk_err_reset_idle: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) rise[5] && !alarm_output_out && !rise[2]
      && !rise[3] && !rise[4] |=> !inverter_reset_out)
      else $error("error reset without fault");

endmodule
`default_nettype wire

// ### core/cesh_pkg.sv
package cesh_pkg;

   // Register byte offsets on the Wishbone slave.
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_WAIT   = 8'h04;
   localparam logic [7:0] ADDR_FREQ   = 8'h08;
   localparam logic [7:0] ADDR_COUNT  = 8'h0C;
   localparam logic [7:0] ADDR_SAVED  = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_HIST   = 8'h18;

   // Control register field positions.
   localparam int CTRL_SEL_LSB   = 0;
   localparam int CTRL_SCOPE_BIT = 2;
   localparam int CTRL_OPM_LSB   = 4;

   // Reset values.
   localparam logic [1:0]  SEL_RST   = 2'h0;
   localparam logic        SCOPE_RST = 1'b0;
   localparam logic [1:0]  OPM_RST   = 2'h1;
   localparam logic [13:0] WAIT_RST  = 14'h0000;
   localparam logic [13:0] FREQ_KEEP = 14'h270F;
   localparam logic [15:0] COUNT_RST = 16'h0000;

   // Stop mode selections and operation modes.
   localparam logic [1:0] SEL_COAST   = 2'h0;
   localparam logic [1:0] SEL_DECEL   = 2'h1;
   localparam logic [1:0] SEL_RESTART = 2'h2;
   localparam logic [1:0] SEL_FALLBK  = 2'h3;
   localparam logic [1:0] OPM_NET     = 2'h0;

   // Fault data codes written to the fault history.
   localparam logic [7:0] CODE_NONE = 8'h00;
   localparam logic [7:0] CODE_LINE = 8'hA1;
   localparam logic [7:0] CODE_OPT  = 8'hF1;

   // Time base: a 0.1 s tick and the hourly save interval.
   localparam int CLK_HZ       = 50_000_000;
   localparam int TICK_TIME_MS = 100;
   localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_TIME_MS;
   localparam int HOUR_TIME_S  = 3600;
   localparam int HOUR_TICKS   = HOUR_TIME_S * 1000 / TICK_TIME_MS;

   typedef enum logic [2:0] {
      ST_NORMAL,
      ST_TIMING,
      ST_FALLBK,
      ST_DECEL,
      ST_TRIP
   } cesh_state_type;

endpackage

// ### sim/cesh_master_model.sv
`timescale 1ns/10ps
`default_nettype none
// Fieldbus master seen from the drive: it drops the link and sends network
// reset requests when the bench tells it to.
module cesh_master_model (
   input  wire logic sys_clk_in,
   input  wire logic link_fail_in,
   input  wire logic err_rst_cmd_in,
   input  wire logic inv_rst_cmd_in,
   output logic      line_error_out,
   output logic      net_error_reset_request_out,
   output logic      net_inverter_reset_out
);
   // Quiet link at time zero so the drive never sees an unknown line.
   initial begin
      line_error_out = 1'b0;
      net_error_reset_request_out = 1'b0;
      net_inverter_reset_out = 1'b0;
   end
   // Requests change only just after an edge, as link refresh data would.
   always @(posedge sys_clk_in) begin
      line_error_out <= link_fail_in;
      net_error_reset_request_out <= err_rst_cmd_in;
      net_inverter_reset_out <= inv_rst_cmd_in;
   end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0, req = 4'h0;
   logic [31:0] wdat = 32'h0000_0000, rdat;
   logic link_fail = 1'b0, opt = 1'b0, stopped = 1'b0, run = 1'b0;
   logic [13:0] spd = 14'h0000;
   wire logic [31:0] wb_dat;
   wire logic ack, line_err, err_req, inv_req, run_o, coast, decel, alarm;
   wire logic fbit, cstop, irst;
   wire logic [13:0] freq;
   wire logic [7:0] ind;
   int bad_count = 0, cmp_count = 0, rst_seen = 0;
   // Clock of 50 MHz.
   always #10 clk = ~clk;
   // Count accepted resets; the pulse lasts a single cycle.
   always @(posedge clk) if (irst === 1'b1) rst_seen++;
   cesh_master_model u_master (.sys_clk_in(clk), .link_fail_in(link_fail),
      .err_rst_cmd_in(req[0]), .inv_rst_cmd_in(req[1]),
      .line_error_out(line_err), .net_error_reset_request_out(err_req),
      .net_inverter_reset_out(inv_req));
   // Short tick and save interval keep the run brief.
   cesh_core #(.TICK_CYCLES(10), .HOUR_TICKS(4)) u_dut (.sys_clk_in(clk),
      .sys_rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
      .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(wb_dat),
      .wb_ack_out(ack), .line_error_in(line_err), .option_fault_in(opt),
      .reset_terminal_in(req[2]), .panel_reset_in(req[3]),
      .net_inverter_reset_in(inv_req), .net_error_reset_request_in(err_req),
      .motor_stopped_in(stopped), .run_cmd_in(run), .speed_cmd_in(spd),
      .run_out(run_o), .freq_out(freq), .coast_out(coast),
      .decel_out(decel), .alarm_output_out(alarm), .fault_bit_out(fbit),
      .line_fault_indication_out(ind), .comm_stop_out(cstop),
      .inverter_reset_out(irst));
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One classic cycle; the request stands until ack is sampled high.
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rdat = wb_dat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (n >= 50) begin
         bad_count++;
         $display("[ERR] %0t bus ack missing", $time);
         give_verdict();
      end
   endtask
   // Bounded wait for the alarm to reach a level.
   task automatic wait_alarm(input logic v);
      int n;
      for (n = 0; n < 40 && alarm !== v; n++) cycles(1);
      if (alarm !== v) begin
         bad_count++;
         $display("[ERR] %0t alarm wait ran out", $time);
         give_verdict();
      end
   endtask
   // Reset request held long enough for the input synchroniser.
   task automatic pulse(input int b);
      @(posedge clk) req[b] <= 1'b1;
      cycles(3);
      @(posedge clk) req[b] <= 1'b0;
      cycles(10);
   endtask
   task automatic s_regs();
      wb(cesh_pkg::ADDR_CTRL, 1'b0, 32'h0);
      chk(rdat, 32'h0000_0010);
      wb(cesh_pkg::ADDR_FREQ, 1'b0, 32'h0);
      chk(rdat, 32'h0000_270F);
      wb(8'h1C, 1'b0, 32'h0);
      chk(rdat, 32'h0000_0000);
   endtask
   task automatic s_coast();
      int r0;
      wb(cesh_pkg::ADDR_CTRL, 1'b1, 32'h0000_0000);
      link_fail <= 1'b1;
      wait_alarm(1'b1);
      chk({coast, fbit}, 32'h0000_0003);
      cycles(2);
      chk(ind, 32'h0000_00A1);
      wb(cesh_pkg::ADDR_COUNT, 1'b0, 32'h0);
      chk(rdat, 32'h0000_0001);
      link_fail <= 1'b0;
      cycles(20);
      chk(alarm, 1'b1);
      r0 = rst_seen;
      pulse(0);
      chk(rst_seen - r0, 32'h0000_0001);
      chk(alarm, 1'b0);
   endtask
   task automatic s_filter();
      wb(cesh_pkg::ADDR_WAIT, 1'b1, 32'h0000_0005);
      link_fail <= 1'b1;
      cycles(20);
      link_fail <= 1'b0;
      cycles(80);
      chk({alarm, coast, decel}, 32'h0000_0000);
   endtask
   task automatic s_fallback();
      run <= 1'b1; spd <= 14'h01F4;
      wb(cesh_pkg::ADDR_FREQ, 1'b1, 32'h0000_0064);
      wb(cesh_pkg::ADDR_CTRL, 1'b1, 32'h0000_0003);
      link_fail <= 1'b1;
      cycles(80);
      chk({alarm, run_o, 2'b00, freq}, 32'h0001_0064);
      link_fail <= 1'b0;
      cycles(10);
      chk(freq, 32'h0000_01F4);
      wb(cesh_pkg::ADDR_FREQ, 1'b1, 32'h0000_270F);
      link_fail <= 1'b1;
      cycles(10);
      spd <= 14'h0123;
      cycles(70);
      chk(freq, 32'h0000_01F4);
      pulse(2);
      link_fail <= 1'b0;
   endtask
   task automatic s_option();
      wb(cesh_pkg::ADDR_CTRL, 1'b1, 32'h0000_0001);
      opt <= 1'b1;
      cycles(8);
      chk({decel, alarm}, 32'h0000_0002);
      stopped <= 1'b1;
      wait_alarm(1'b1);
      cycles(2);
      chk(ind, 32'h0000_00F1);
      opt <= 1'b0;
      cycles(10);
      chk(alarm, 1'b1);
      pulse(3);
      chk(alarm, 1'b0);
      stopped <= 1'b0;
   endtask
   task automatic s_modes();
      int r0;
      wb(cesh_pkg::ADDR_WAIT, 1'b1, 32'h0000_0000);
      wb(cesh_pkg::ADDR_CTRL, 1'b1, 32'h0000_0000);
      link_fail <= 1'b1;
      wait_alarm(1'b1);
      link_fail <= 1'b0;
      wb(cesh_pkg::ADDR_CTRL, 1'b1, 32'h0000_0014);
      r0 = rst_seen;
      pulse(0);
      pulse(1);
      chk(rst_seen - r0, 32'h0000_0000);
      chk(alarm, 1'b1);
      opt <= 1'b1;
      cycles(10);
      chk({alarm, cstop}, 32'h0000_0003);
      opt <= 1'b0;
      pulse(2);
      chk({alarm, 31'(rst_seen - r0)}, 32'h0000_0001);
      wb(cesh_pkg::ADDR_CTRL, 1'b1, 32'h0000_0003);
      pulse(0);
      chk(rst_seen - r0, 32'h0000_0001);
      opt <= 1'b1;
      wait_alarm(1'b1);
      chk({coast, decel}, 32'h0000_0002);
      opt <= 1'b0;
      pulse(3);
      chk(alarm, 1'b0);
   endtask
   // Selection 2: the error clears mid-ramp and the old command returns.
   task automatic s_restart();
      wb(cesh_pkg::ADDR_CTRL, 1'b1, 32'h0000_0002);
      spd <= 14'h0050;
      link_fail <= 1'b1;
      cycles(8);
      chk({decel, alarm}, 32'h0000_0002);
      spd <= 14'h0060;
      link_fail <= 1'b0;
      cycles(8);
      chk({decel, run_o}, 32'h0000_0001);
      chk(freq, 32'h0000_0050);
   endtask
   initial begin
      cycles(3);
      rst <= 1'b0;
      s_regs();
      s_coast();
      s_filter();
      s_fallback();
      s_option();
      s_modes();
      s_restart();
      give_verdict();
   end
endmodule
`default_nettype wire
